// ---- lin_uart_defines.vh ----
// constants for the lin break and baud generator block
// included by lin_uart_break.v; holds definitions only
`ifndef LIN_UART_DEFINES_VH
`define LIN_UART_DEFINES_VH
`define BRK_LEN_BASE 5'h0D
`define BRK_RX_MIN_BITS 4'hB
`define CLKSEL_TIMER 4'hB
`define CLKSEL_MAX_DIV 4'hA
`define DIVISOR_MIN 8'h04
`define RXBUF_RESET 8'hFF
`define FRAME_BITS 4'hA
`endif

// ---- lin_uart_break.v ----
// uart core for lin: break transmit/receive, baud generator, 8n1 data path
// assumes all inputs synchronous to CLOCK; control bits are plain ports
// What this block does
// - power bit set drives transmit pin high idle
// - trigger write with power and transmit enable starts break transmission
// - break holds pin low 13 to 20 bit times per length field
// - break end pulses transmit-complete, clears trigger, returns to normal mode
// - after break, transmitter idles until new data or new trigger
// - break-receive enable arms break reception; start detection as normal
// - low of 11+ bits raises receive-complete, clears flag and enable
// - valid break sets no overrun, parity or framing error
// - break does not load receive buffer; reset value kept
// - low of 9 or 10 bits: no interrupt, stay armed; shorter low ends as data frame
// - base clock reaches logic only while power bit set
// - separate 9-bit transmit and receive divide counters
// - transmit counter held zero unless power and transmit enable
// - transmit counter cleared on first write and each frame end
// - receive counter zero when disabled, runs from start to frame end
// - divisor k 4..255, baud equals base clock over 2k
// - clock select picks prescaler 2^n for 0..10, timer for 11
// - receive input filtered: two equal base-clock samples accepted
// - falling edge starts counter; low after k counts is start bit
`timescale 1ns/1ps
`include "lin_uart_defines.vh"
module lin_uart_break (
  input wire CLOCK,
  input wire RST,
  input wire UNIT_POWER_BIT,
  input wire TRANSMIT_ENABLE_BIT,
  input wire RECEIVE_ENABLE_BIT,
  input wire [3:0] BASE_CLOCK_SELECT,
  input wire [7:0] BAUD_DIVISOR_K,
  input wire [2:0] BREAK_LENGTH_FIELD,
  input wire BREAK_TRIGGER_WR,
  input wire BREAK_RX_ENABLE_WR,
  input wire TX_WRITE,
  input wire [7:0] TX_DATA,
  input wire AUX_TIMER_OUTPUT,
  input wire SERIAL_RX_PIN,
  output reg SERIAL_TX_PIN,
  output reg BREAK_TRANSMIT_TRIGGER,
  output reg BREAK_RECEIVE_ENABLE,
  output reg BREAK_RECEIVED_FLAG,
  output reg TRANSMIT_COMPLETE_IRQ,
  output reg RECEIVE_COMPLETE_IRQ,
  output reg [7:0] RECEIVE_BUFFER,
  output reg OVERRUN_ERROR_FLAG,
  output reg FRAMING_ERROR_FLAG,
  output reg PARITY_ERROR_FLAG,
  input wire RX_BUFFER_READ
);
  localparam TX_IDLE = 2'h0;
  localparam TX_DATA_S = 2'h1;
  localparam TX_BREAK = 2'h2;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;

  // prescaler: base clock as a one-cycle enable
  reg [9:0] pre_reg;
  reg aux_d_reg;
  reg base_en;
  wire tx_on = UNIT_POWER_BIT & TRANSMIT_ENABLE_BIT;
  wire rx_on = UNIT_POWER_BIT & RECEIVE_ENABLE_BIT;
  always @(posedge CLOCK) begin
    if (RST | ~UNIT_POWER_BIT) begin
      pre_reg <= 10'h000;
      aux_d_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 10'h001;
      aux_d_reg <= AUX_TIMER_OUTPUT;
    end
  end
  // prescaler bits that must all be ones for a 2^n tick; a table keeps every index in range
  reg [9:0] pre_mask;
  always @* begin
    case (BASE_CLOCK_SELECT)
      4'h0: pre_mask = 10'h000;
      4'h1: pre_mask = 10'h001;
      4'h2: pre_mask = 10'h003;
      4'h3: pre_mask = 10'h007;
      4'h4: pre_mask = 10'h00F;
      4'h5: pre_mask = 10'h01F;
      4'h6: pre_mask = 10'h03F;
      4'h7: pre_mask = 10'h07F;
      4'h8: pre_mask = 10'h0FF;
      4'h9: pre_mask = 10'h1FF;
      4'hA: pre_mask = 10'h3FF;
      default: pre_mask = 10'h000;
    endcase
  end
  always @* begin
    base_en = 1'b0;
    if (UNIT_POWER_BIT) begin
      // the aux timer acts as a clock through its rising edges only
      if (BASE_CLOCK_SELECT == `CLKSEL_TIMER)
        base_en = AUX_TIMER_OUTPUT & ~aux_d_reg;
      else if (BASE_CLOCK_SELECT <= `CLKSEL_MAX_DIV)
        base_en = ((pre_reg & pre_mask) == pre_mask);
    end
  end

  // divisor below 4 is clamped; half bit = k base clocks, bit = 2k
  wire [7:0] k_val = (BAUD_DIVISOR_K < `DIVISOR_MIN) ? `DIVISOR_MIN : BAUD_DIVISOR_K;
  wire [8:0] bit_len = {k_val, 1'b0};

  // transmitter
  // a break counts whole base ticks from its trigger edge, so with a divided base clock
  // the low time may fall short by part of one base period
  reg [1:0] tx_state_reg;
  reg [8:0] tx_cnt_reg;
  reg [4:0] tx_bits_reg;
  reg [9:0] tx_shift_reg;
  wire tx_tick = base_en && (tx_cnt_reg == bit_len - 9'h001);
  always @(posedge CLOCK) begin
    if (RST) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 9'h000;
      tx_bits_reg <= 5'h00;
      tx_shift_reg <= 10'h3FF;
      SERIAL_TX_PIN <= 1'b1;
      BREAK_TRANSMIT_TRIGGER <= 1'b0;
      TRANSMIT_COMPLETE_IRQ <= 1'b0;
    end else begin
      TRANSMIT_COMPLETE_IRQ <= 1'b0;
      if (!tx_on) begin
        tx_cnt_reg <= 9'h000;
        tx_state_reg <= TX_IDLE;
        SERIAL_TX_PIN <= 1'b1;
        BREAK_TRANSMIT_TRIGGER <= 1'b0;
      end else begin
        if (base_en)
          tx_cnt_reg <= tx_tick ? 9'h000 : tx_cnt_reg + 9'h001;
        case (tx_state_reg)
          TX_IDLE: begin
            SERIAL_TX_PIN <= 1'b1;
            if (BREAK_TRIGGER_WR) begin
              BREAK_TRANSMIT_TRIGGER <= 1'b1;
              tx_state_reg <= TX_BREAK;
              tx_cnt_reg <= 9'h000;
              tx_bits_reg <= `BRK_LEN_BASE + {2'b00, BREAK_LENGTH_FIELD};
              SERIAL_TX_PIN <= 1'b0;
            end else if (TX_WRITE) begin
              tx_cnt_reg <= 9'h000;
              // start bit goes out at once so the stop bit is whole before the interrupt
              SERIAL_TX_PIN <= 1'b0;
              tx_shift_reg <= {1'b1, TX_DATA, 1'b0};
              tx_bits_reg <= {1'b0, `FRAME_BITS};
              tx_state_reg <= TX_DATA_S;
            end
          end
          TX_DATA_S: begin
            if (tx_tick) begin
              SERIAL_TX_PIN <= tx_shift_reg[1];
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_bits_reg <= tx_bits_reg - 5'h01;
              if (tx_bits_reg == 5'h01) begin
                TRANSMIT_COMPLETE_IRQ <= 1'b1;
                tx_state_reg <= TX_IDLE;
              end
            end
          end
          TX_BREAK: begin
            SERIAL_TX_PIN <= 1'b0;
            if (tx_tick) begin
              tx_bits_reg <= tx_bits_reg - 5'h01;
              if (tx_bits_reg == 5'h01) begin
                SERIAL_TX_PIN <= 1'b1;
                TRANSMIT_COMPLETE_IRQ <= 1'b1;
                BREAK_TRANSMIT_TRIGGER <= 1'b0;
                tx_state_reg <= TX_IDLE;
              end
            end
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // receive noise filter on base clock
  reg rx_s1_reg;
  reg rx_s2_reg;
  reg rx_f_reg;
  reg rx_f_d_reg;
  always @(posedge CLOCK) begin
    if (RST) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_f_reg <= 1'b1;
    end else if (base_en) begin
      rx_s1_reg <= SERIAL_RX_PIN;
      rx_s2_reg <= rx_s1_reg;
      if (rx_s1_reg == rx_s2_reg)
        rx_f_reg <= rx_s2_reg;
    end
  end

  // receiver
  reg [1:0] rx_state_reg;
  reg [8:0] rx_cnt_reg;
  reg [3:0] rx_bits_reg;
  reg [7:0] rx_shift_reg;
  reg rx_all_low_reg;
  reg rx_full_reg;
  wire rx_half = base_en && (rx_cnt_reg == {1'b0, k_val} - 9'h001);
  wire rx_full = base_en && (rx_cnt_reg == bit_len - 9'h001);
  always @(posedge CLOCK) begin
    if (RST) begin
      rx_f_d_reg <= 1'b1;
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 9'h000;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_all_low_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      RECEIVE_BUFFER <= `RXBUF_RESET;
      BREAK_RECEIVE_ENABLE <= 1'b0;
      BREAK_RECEIVED_FLAG <= 1'b0;
      RECEIVE_COMPLETE_IRQ <= 1'b0;
      OVERRUN_ERROR_FLAG <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
      PARITY_ERROR_FLAG <= 1'b0;
    end else begin
      RECEIVE_COMPLETE_IRQ <= 1'b0;
      if (base_en)
        rx_f_d_reg <= rx_f_reg;
      // a read clears first, so an error raised in the same cycle survives
      if (RX_BUFFER_READ) begin
        rx_full_reg <= 1'b0;
        OVERRUN_ERROR_FLAG <= 1'b0;
        FRAMING_ERROR_FLAG <= 1'b0;
      end
      if (BREAK_RX_ENABLE_WR && rx_on) begin
        BREAK_RECEIVE_ENABLE <= 1'b1;
        BREAK_RECEIVED_FLAG <= 1'b1;
      end
      if (!rx_on) begin
        rx_cnt_reg <= 9'h000;
        rx_state_reg <= RX_IDLE;
      end else begin
        case (rx_state_reg)
          RX_IDLE: begin
            rx_cnt_reg <= 9'h000;
            if (base_en && rx_f_d_reg && !rx_f_reg)
              rx_state_reg <= RX_START;
          end
          RX_START: begin
            if (base_en)
              rx_cnt_reg <= rx_cnt_reg + 9'h001;
            if (rx_half) begin
              rx_cnt_reg <= 9'h000;
              if (!rx_f_reg) begin
                rx_state_reg <= RX_BITS;
                rx_bits_reg <= 4'h0;
                rx_all_low_reg <= 1'b1;
              end else
                rx_state_reg <= RX_IDLE;
            end
          end
          RX_BITS: begin
            if (base_en)
              rx_cnt_reg <= rx_full ? 9'h000 : rx_cnt_reg + 9'h001;
            if (rx_full) begin
              rx_bits_reg <= rx_bits_reg + 4'h1;
              if (rx_bits_reg < 4'h8) begin
                rx_shift_reg <= {rx_f_reg, rx_shift_reg[7:1]};
                if (rx_f_reg)
                  rx_all_low_reg <= 1'b0;
              end else if (BREAK_RECEIVE_ENABLE && rx_all_low_reg) begin
                // break: stop-bit slot samples the 10th bit; wait for high
                if (rx_f_reg) begin
                  rx_state_reg <= RX_IDLE;
                  // a rise first seen at slot ten or later means over ten and a half bits low
                  if (rx_bits_reg >= `BRK_RX_MIN_BITS - 4'h1) begin
                    RECEIVE_COMPLETE_IRQ <= 1'b1;
                    BREAK_RECEIVE_ENABLE <= 1'b0;
                    BREAK_RECEIVED_FLAG <= 1'b0;
                  end
                end else if (rx_bits_reg == 4'hF)
                  rx_bits_reg <= 4'hF;
                // no error flags, no buffer load on this path
              end else begin
                rx_state_reg <= RX_IDLE;
                RECEIVE_COMPLETE_IRQ <= 1'b1;
                FRAMING_ERROR_FLAG <= ~rx_f_reg;
                if (rx_full_reg)
                  OVERRUN_ERROR_FLAG <= 1'b1;
                else begin
                  RECEIVE_BUFFER <= rx_shift_reg;
                  rx_full_reg <= 1'b1;
                end
              end
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end
endmodule // lin_uart_break

// ---- lin_props.sv ----
// assertions on the ports of the lin break and baud block
// bound to lin_uart_break; inputs are held steady while a break runs
`timescale 1ns/1ps
module lin_props (
  input wire CLOCK, input wire RST, input wire UNIT_POWER_BIT, input wire TRANSMIT_ENABLE_BIT,
  input wire RECEIVE_ENABLE_BIT, input wire [3:0] BASE_CLOCK_SELECT, input wire [7:0] BAUD_DIVISOR_K,
  input wire [2:0] BREAK_LENGTH_FIELD, input wire BREAK_TRIGGER_WR, input wire BREAK_RX_ENABLE_WR,
  input wire SERIAL_TX_PIN, input wire BREAK_TRANSMIT_TRIGGER, input wire BREAK_RECEIVE_ENABLE,
  input wire BREAK_RECEIVED_FLAG, input wire TRANSMIT_COMPLETE_IRQ, input wire RECEIVE_COMPLETE_IRQ,
  input wire [7:0] RECEIVE_BUFFER, input wire OVERRUN_ERROR_FLAG, input wire FRAMING_ERROR_FLAG
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // length check knows prescaler ticks only; the aux timer rate is unknown here
  logic [19:0] lo_cnt;
  wire [7:0] kk = (BAUD_DIVISOR_K < 8'h04) ? 8'h04 : BAUD_DIVISOR_K;
  wire [19:0] want = ((20'h0D + BREAK_LENGTH_FIELD) * kk * 20'h2) << BASE_CLOCK_SELECT;
  always @(posedge CLOCK) begin
    lo_cnt <= (RST || !BREAK_TRANSMIT_TRIGGER) ? 20'h0 : lo_cnt + {19'h0, !SERIAL_TX_PIN};
  end
  sequence brk_go;
    BREAK_TRIGGER_WR && UNIT_POWER_BIT && TRANSMIT_ENABLE_BIT && !BREAK_TRANSMIT_TRIGGER;
  endsequence
  sequence brk_end;
    $fell(BREAK_TRANSMIT_TRIGGER);
  endsequence
  a_power_idle: assert property ($rose(UNIT_POWER_BIT) |=> SERIAL_TX_PIN) else $error("tx low at power on");
  a_break_start: assert property (brk_go |=> BREAK_TRANSMIT_TRIGGER && !SERIAL_TX_PIN)
    else $error("break did not start");
  a_break_refused: assert property (BREAK_TRIGGER_WR && !TRANSMIT_ENABLE_BIT && !BREAK_TRANSMIT_TRIGGER
    |=> !BREAK_TRANSMIT_TRIGGER) else $error("break started while disabled");
  a_break_len: assert property ((brk_end and (BASE_CLOCK_SELECT <= 4'hA)) |-> lo_cnt == want)
    else $error("break low length wrong");
  a_break_end: assert property (brk_end |-> TRANSMIT_COMPLETE_IRQ && SERIAL_TX_PIN)
    else $error("break end without irq");
  a_tx_irq_pulse: assert property (TRANSMIT_COMPLETE_IRQ |=> !TRANSMIT_COMPLETE_IRQ) else $error("tx irq long");
  a_rx_arm: assert property (BREAK_RX_ENABLE_WR && UNIT_POWER_BIT && RECEIVE_ENABLE_BIT
    |=> BREAK_RECEIVE_ENABLE && BREAK_RECEIVED_FLAG) else $error("break receive not armed");
  a_rx_clear: assert property (RECEIVE_COMPLETE_IRQ && $past(BREAK_RECEIVE_ENABLE)
    |-> !BREAK_RECEIVE_ENABLE && !BREAK_RECEIVED_FLAG) else $error("break bits not cleared");
  a_rx_silent: assert property ($fell(BREAK_RECEIVE_ENABLE) |-> RECEIVE_COMPLETE_IRQ)
    else $error("break mode left silently");
  a_rx_quiet: assert property ($past(BREAK_RECEIVE_ENABLE) |-> $stable(RECEIVE_BUFFER)
    && !$rose(FRAMING_ERROR_FLAG) && !$rose(OVERRUN_ERROR_FLAG)) else $error("buffer or error touched");
endmodule // lin_props
bind lin_uart_break lin_props lin_props_i (.CLOCK, .RST, .UNIT_POWER_BIT, .TRANSMIT_ENABLE_BIT,
  .RECEIVE_ENABLE_BIT, .BASE_CLOCK_SELECT, .BAUD_DIVISOR_K, .BREAK_LENGTH_FIELD, .BREAK_TRIGGER_WR,
  .BREAK_RX_ENABLE_WR, .SERIAL_TX_PIN, .BREAK_TRANSMIT_TRIGGER, .BREAK_RECEIVE_ENABLE, .BREAK_RECEIVED_FLAG,
  .TRANSMIT_COMPLETE_IRQ, .RECEIVE_COMPLETE_IRQ, .RECEIVE_BUFFER, .OVERRUN_ERROR_FLAG, .FRAMING_ERROR_FLAG);

// ---- lin_node.sv ----
// far lin node: drives the rx line and counts low tx cycles
// the bus has a pull-up, so a released line reads high
`timescale 1ns/1ps
module lin_node (
  input wire clk,
  input wire tx,
  output reg rx
);
  integer tx_low = 0;
  initial rx = 1'b1;
  always @(posedge clk) begin
    if (!tx) tx_low <= tx_low + 1;
  end
  task send_low(input integer n);
    begin
      @(negedge clk) rx = 1'b0;
      repeat (n) @(negedge clk);
      rx = 1'b1;
    end
  endtask
endmodule // lin_node

// ---- tb.sv ----
// testbench: break transmit, break receive and divider settings
// assumes lin_node on the serial side; inputs change on falling edges
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, rst = 1'b1, pwr = 1'b0, txe = 1'b0, rxe = 1'b0, aux = 1'b0, btw = 1'b0, brw = 1'b0, txw = 1'b0;
  reg [3:0] sel = 4'h0;
  reg [7:0] k = 8'h04;
  reg [2:0] len = 3'h0;
  wire rxl, tx, trig, ren, rflag, tirq, rirq, ove, fe, pe;
  wire [7:0] rbuf;
  integer err_total = 0, checked = 0, n_rirq = 0, i, w, e, b;
  always #12.5 clk = ~clk;
  always @(negedge clk) aux <= ~aux;
  always @(posedge clk) begin
    if (rirq) n_rirq <= n_rirq + 1;
  end
  lin_uart_break lin_uart_break_i (.CLOCK(clk), .RST(rst), .UNIT_POWER_BIT(pwr), .TRANSMIT_ENABLE_BIT(txe),
    .RECEIVE_ENABLE_BIT(rxe), .BASE_CLOCK_SELECT(sel), .BAUD_DIVISOR_K(k), .BREAK_LENGTH_FIELD(len),
    .BREAK_TRIGGER_WR(btw), .BREAK_RX_ENABLE_WR(brw), .TX_WRITE(txw), .TX_DATA(8'h55), .AUX_TIMER_OUTPUT(aux),
    .SERIAL_RX_PIN(rxl), .SERIAL_TX_PIN(tx), .BREAK_TRANSMIT_TRIGGER(trig), .BREAK_RECEIVE_ENABLE(ren),
    .BREAK_RECEIVED_FLAG(rflag), .TRANSMIT_COMPLETE_IRQ(tirq), .RECEIVE_COMPLETE_IRQ(rirq),
    .RECEIVE_BUFFER(rbuf), .OVERRUN_ERROR_FLAG(ove), .FRAMING_ERROR_FLAG(fe), .PARITY_ERROR_FLAG(pe),
    .RX_BUFFER_READ(1'b0));
  lin_node lin_node_i (.clk(clk), .tx(tx), .rx(rxl));
  task chk(input [31:0] seen, input [31:0] want, input [63:0] nm);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s expected %0h seen %0h", nm, want, seen);
      end
    end
  endtask
  // 0 break trigger, 1 break receive arm, 2 buffer write
  task pulse(input integer s);
    begin
      @(negedge clk) {btw, brw, txw} = 3'b100 >> s;
      @(negedge clk) {btw, brw, txw} = 3'b000;
    end
  endtask
  task wait_irq(input integer r, input integer lim);
    begin
      w = 0;
      while ((r ? rirq : tirq) !== 1'b1 && w < lim) begin
        @(posedge clk);
        #1 w = w + 1;
      end
      chk(w < lim, 1, "irq_wait");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(rbuf, 8'hFF, "rbuf_rst");
    @(negedge clk) pwr = 1'b1;
    @(negedge clk) chk(tx, 1, "tx_idle");
    pulse(0);
    chk(trig, 0, "refused");
    txe = 1'b1;
    rxe = 1'b1;
    // last pass runs from the aux timer, whose tick phase blurs the length
    for (i = 0; i < 9; i = i + 1) begin
      repeat (2) @(negedge clk);
      len = i[2:0];
      sel = (i == 8) ? 4'hB : {3'h0, i[0]};
      k = 8'h04 + i[7:0];
      e = ((13 + len) * 2 * k) << ((i == 8) ? 1 : sel);
      b = lin_node_i.tx_low;
      pulse(0);
      chk(trig, 1, "trig_set");
      wait_irq(0, 2000);
      chk(trig, 0, "trig_clr");
      if (i < 8) chk(lin_node_i.tx_low - b, e, "brk_len");
      else chk(lin_node_i.tx_low - b >= e - 4 && lin_node_i.tx_low - b <= e + 4, 1, "aux_len");
    end
    repeat (2) @(negedge clk);
    sel = 4'h0;
    k = 8'h04;
    b = lin_node_i.tx_low;
    repeat (20) @(negedge clk);
    chk(lin_node_i.tx_low - b, 0, "tx_hold");
    pulse(2);
    wait_irq(0, 400);
    repeat (80) @(negedge clk);
    chk(lin_node_i.tx_low - b, 40, "frame");
    pulse(1);
    chk(ren, 1, "arm_en");
    chk(rflag, 1, "arm_flag");
    lin_node_i.send_low(72);
    repeat (40) @(negedge clk);
    chk(n_rirq, 0, "shortirq");
    chk(ren, 1, "short_en");
    chk(rflag, 1, "shortflg");
    lin_node_i.send_low(96);
    wait_irq(1, 400);
    chk(ren, 0, "long_en");
    chk(rflag, 0, "longflag");
    chk({ove, fe, pe}, 0, "errors");
    chk(rbuf, 8'hFF, "rbuf");
    report_and_stop;
  end
endmodule // tb
